/* logic/baud_tick_gen.sv */
// Baud tick generator: coarse and fine prescalers feeding a bit-rate divider
`timescale 1ns/1ps
module baud_tick_gen
  import serial_ctrl_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [1:0] rate_pre_div_sel,
  input wire logic [2:0] rate_div_sel,
  input wire logic [2:0] fine_pre_div_sel,
  input wire logic [4:0] fine_pre_frac,
  output logic bit_tick
);

  // ****************************************
  // Divisor decoding
  // ****************************************
  // Coarse prescaler divisor from its two-bit code
  function automatic logic [3:0] pre_divisor(input logic [1:0] sel);
    case (sel)
      2'b00: pre_divisor = 4'h1;
      2'b01: pre_divisor = 4'h3;
      2'b10: pre_divisor = 4'h4;
      default: pre_divisor = 4'hD;
    endcase
  endfunction : pre_divisor

  logic [3:0] fine_div; // Fine integer divisor, 1 when bypassed
  logic [7:0] rate_divisor; // Power of two rate divisor
  logic [3:0] pre_div; // Coarse prescaler divisor
  logic [4:0] fine_cnt_ff, nxt_fine_cnt; // Fine prescaler counter
  logic [5:0] frac_acc_ff, nxt_frac_acc; // Fractional accumulator
  logic stretch_ff, nxt_stretch; // One extra clock pending
  logic [3:0] pre_cnt_ff, nxt_pre_cnt; // Coarse prescaler counter
  logic [13:0] rate_cnt_ff, nxt_rate_cnt; // 64 x rate divisor counter
  logic bit_tick_ff, nxt_bit_tick;
  logic fine_out;
  logic [13:0] rate_top;

  assign pre_div = pre_divisor(rate_pre_div_sel);
  assign rate_divisor = 8'h01 << rate_div_sel;
  // Zero code bypasses the fine stage entirely
  assign fine_div = (fine_pre_div_sel == 3'h0) ? 4'h1 : {1'b0, fine_pre_div_sel} + 4'h1;
  assign rate_top = 14'(rate_divisor * OVERSAMPLE) - 14'h1;
  assign fine_out = (fine_cnt_ff == 5'(fine_div - 4'h1)) && !stretch_ff;
  assign bit_tick = bit_tick_ff;

  // ****************************************
  // Next-state chain: fine, coarse, rate
  // ****************************************
  // Fraction adds extra cycles: frac/32 per fine period on average
  always_comb
  begin
    nxt_fine_cnt = fine_cnt_ff;
    nxt_frac_acc = frac_acc_ff;
    nxt_stretch = 1'b0;
    nxt_pre_cnt = pre_cnt_ff;
    nxt_rate_cnt = rate_cnt_ff;
    nxt_bit_tick = 1'b0;
    if (stretch_ff)
    begin
      nxt_fine_cnt = 5'h0; // Inserted cycle, no output
    end
    else if (fine_out)
    begin
      nxt_fine_cnt = 5'h0;
      if (fine_pre_div_sel != 3'h0)
      begin
        // Accumulate fraction, insert a clock on overflow
        if (frac_acc_ff + 6'(fine_pre_frac) >= FRAC_STEPS)
        begin
          nxt_frac_acc = frac_acc_ff + 6'(fine_pre_frac) - FRAC_STEPS;
          nxt_stretch = 1'b1;
        end
        else
        begin
          nxt_frac_acc = frac_acc_ff + 6'(fine_pre_frac);
        end
      end
      // Coarse prescaler and rate stage advance on fine output
      if (pre_cnt_ff >= pre_div - 4'h1)
      begin
        nxt_pre_cnt = 4'h0;
        if (rate_cnt_ff >= rate_top)
        begin
          nxt_rate_cnt = 14'h0;
          nxt_bit_tick = 1'b1;
        end
        else
        begin
          nxt_rate_cnt = rate_cnt_ff + 14'h1;
        end
      end
      else
      begin
        nxt_pre_cnt = pre_cnt_ff + 4'h1;
      end
    end
    else
    begin
      nxt_fine_cnt = fine_cnt_ff + 5'h1;
    end
  end

  // Register stage
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fine_cnt_ff <= 5'h0;
      frac_acc_ff <= 6'h0;
      stretch_ff <= 1'b0;
      pre_cnt_ff <= 4'h0;
      rate_cnt_ff <= 14'h0;
      bit_tick_ff <= 1'b0;
    end
    else
    begin
      fine_cnt_ff <= nxt_fine_cnt;
      frac_acc_ff <= nxt_frac_acc;
      stretch_ff <= nxt_stretch;
      pre_cnt_ff <= nxt_pre_cnt;
      rate_cnt_ff <= nxt_rate_cnt;
      bit_tick_ff <= nxt_bit_tick;
    end
  end

  // Ticks never come back to back
  tick_single_a: assert property (@(posedge pclk) disable iff (!presetn)
    bit_tick |=> !bit_tick) else $error("bit tick lasted more than one cycle");

endmodule : baud_tick_gen

/* logic/serial_ctrl_top.sv */
// Serial control top: APB registers, interrupts and transmit line sequencing
`timescale 1ns/1ps
module serial_ctrl_top
  import serial_ctrl_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic tx_char_valid,
  input wire logic tx_nine_bit,
  input wire logic [8:0] tx_char,
  output logic tx_pin,
  output logic tx_char_taken,
  output logic [7:0] ctrl_two_out,
  output logic bit_tick_out,
  output logic irq
);

  // ****************************************
  // Registers and decode
  // ****************************************
  ctrl_two_t ctrl_ff, nxt_ctrl; // Second control register
  logic [7:0] baud_ff, nxt_baud; // Divider selects
  logic [7:0] fine_ff, nxt_fine; // Fine prescaler
  logic unit_on_ff, nxt_unit_on; // Global serial enable
  events_t flags_ff, nxt_flags; // Level event flags
  events_t stat_ff, nxt_stat; // Sticky status
  events_t mask_ff, nxt_mask; // Interrupt mask
  logic [31:0] prdata_ff, nxt_prdata;
  logic pslverr_ff, nxt_pslverr;
  logic irq_ff, nxt_irq;
  logic bit_tick;
  logic wr_en; // Access phase write
  logic rd_en; // Access phase read
  logic mapped;
  events_t irq_en; // Per-event enables from control register two
  logic tx_done_evt;

  // Zero wait state slave: access phase always completes
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign mapped = (paddr == CTRL_TWO_ADDR) || (paddr == BAUD_ADDR) || (paddr == FINE_ADDR) ||
                  (paddr == GLOBAL_ADDR) || (paddr == STATUS_ADDR) || (paddr == MASK_ADDR) ||
                  (paddr == EVENT_ADDR);
  assign irq_en = {ctrl_ff.tx_empty_irq_en, ctrl_ff.tx_done_irq_en,
                   ctrl_ff.rx_full_irq_en, ctrl_ff.quiet_line_irq_en};

  // Register read view, reserved bits as zero
  function automatic logic [31:0] read_mux(input logic [7:0] addr, input ctrl_two_t c,
    input logic [7:0] b, input logic [7:0] f, input logic u, input events_t s,
    input events_t m, input events_t fl);
    case (addr)
      CTRL_TWO_ADDR: read_mux = {24'h000000, c};
      BAUD_ADDR: read_mux = {24'h000000, b};
      FINE_ADDR: read_mux = {24'h000000, f};
      GLOBAL_ADDR: read_mux = {31'h00000000, u};
      STATUS_ADDR: read_mux = {28'h0000000, s};
      MASK_ADDR: read_mux = {28'h0000000, m};
      EVENT_ADDR: read_mux = {28'h0000000, fl};
      default: read_mux = 32'h00000000;
    endcase
  endfunction : read_mux

  // ****************************************
  // Register file next state
  // ****************************************
  // Sticky bits: hardware set wins over a write-one clear in the same cycle
  always_comb
  begin
    nxt_ctrl = ctrl_ff;
    nxt_baud = baud_ff;
    nxt_fine = fine_ff;
    nxt_unit_on = unit_on_ff;
    nxt_flags = flags_ff;
    nxt_mask = mask_ff;
    nxt_stat = stat_ff;
    nxt_prdata = prdata_ff;
    nxt_pslverr = 1'b0;
    if (wr_en)
    begin
      case (paddr)
        CTRL_TWO_ADDR:
        begin
          nxt_ctrl = ctrl_two_t'(pwdata[7:0]);
          // Writes to tx_on are dropped while the unit is off
          if (!unit_on_ff)
          begin
            nxt_ctrl.tx_on = ctrl_ff.tx_on;
          end
        end
        BAUD_ADDR: nxt_baud = pwdata[7:0];
        FINE_ADDR: nxt_fine = pwdata[7:0];
        GLOBAL_ADDR: nxt_unit_on = pwdata[0];
        STATUS_ADDR: nxt_stat = stat_ff & ~events_t'(pwdata[3:0]);
        MASK_ADDR: nxt_mask = events_t'(pwdata[3:0]);
        EVENT_ADDR: nxt_flags = events_t'(pwdata[3:0]);
        default: nxt_pslverr = 1'b1; // Unmapped address
      endcase
    end
    if (rd_en)
    begin
      nxt_prdata = read_mux(paddr, ctrl_ff, baud_ff, fine_ff, unit_on_ff,
                            stat_ff, mask_ff, flags_ff);
      nxt_pslverr = !mapped;
    end
    // Transmit completion drives the done flag level
    if (tx_done_evt)
    begin
      nxt_flags.tx_done_flag = 1'b1;
    end
    // Each enabled flag latches a sticky event
    nxt_stat = nxt_stat | (flags_ff & irq_en);
    nxt_irq = |(stat_ff & mask_ff & irq_en);
  end

  // Register file flops
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_ff <= ctrl_two_t'(CTRL_TWO_RESET);
      baud_ff <= BAUD_RESET;
      fine_ff <= FINE_RESET;
      unit_on_ff <= 1'b0;
      flags_ff <= '0;
      stat_ff <= '0;
      mask_ff <= '0;
      prdata_ff <= 32'h00000000;
      pslverr_ff <= 1'b0;
      irq_ff <= 1'b0;
    end
    else
    begin
      ctrl_ff <= nxt_ctrl;
      baud_ff <= nxt_baud;
      fine_ff <= nxt_fine;
      unit_on_ff <= nxt_unit_on;
      flags_ff <= nxt_flags;
      stat_ff <= nxt_stat;
      mask_ff <= nxt_mask;
      prdata_ff <= nxt_prdata;
      pslverr_ff <= nxt_pslverr;
      irq_ff <= nxt_irq;
    end
  end

  // APB answers in the access cycle with read data decoded straight from paddr
  assign pready = 1'b1;
  assign prdata = read_mux(paddr, ctrl_ff, baud_ff, fine_ff, unit_on_ff,
                           stat_ff, mask_ff, flags_ff);
  assign pslverr = psel && penable && !mapped;
  assign ctrl_two_out = ctrl_ff;
  assign irq = irq_ff;

  // ****************************************
  // Shared bit-rate generator
  // ****************************************
  // One tick stream serves the transmitter and bit_tick_out
  baud_tick_gen u_baud
  (
    .pclk(pclk),
    .presetn(presetn),
    .rate_pre_div_sel(baud_ff[PRE_SEL_LSB +: 2]),
    .rate_div_sel(baud_ff[RATE_SEL_LSB +: 3]),
    .fine_pre_div_sel(fine_ff[FINE_PDS_LSB +: 3]),
    .fine_pre_frac(fine_ff[FINE_FRAC_W - 1:0]),
    .bit_tick(bit_tick)
  );
  assign bit_tick_out = bit_tick;

  // ****************************************
  // Transmit line sequencer
  // ****************************************
  tx_state_t tx_state_ff, nxt_tx_state;
  logic [3:0] bit_cnt_ff, nxt_bit_cnt; // Bits left in this frame
  logic [11:0] shift_ff, nxt_shift; // LSB first, stop bits as ones
  logic tx_on_seen_ff, nxt_tx_on_seen; // tx_on of previous cycle
  logic idle_q_ff, nxt_idle_q; // Queued idle character
  logic taken_ff, nxt_taken;
  logic done_ff, nxt_done;

  assign tx_done_evt = done_ff;
  assign tx_pin = shift_ff[0];
  assign tx_char_taken = taken_ff;

  // Sequencer: preamble, characters, idle, back to high
  always_comb
  begin
    nxt_tx_state = tx_state_ff;
    nxt_bit_cnt = bit_cnt_ff;
    nxt_shift = shift_ff;
    nxt_tx_on_seen = ctrl_ff.tx_on;
    nxt_idle_q = idle_q_ff;
    nxt_taken = 1'b0;
    nxt_done = 1'b0;
    // Off then on again during a character frame queues one idle character
    if (tx_state_ff == TX_CHAR && ctrl_ff.tx_on && !tx_on_seen_ff)
    begin
      nxt_idle_q = 1'b1;
    end
    case (tx_state_ff)
      TX_IDLE:
      begin
        nxt_shift = 12'hFFF;
        if (ctrl_ff.tx_on && !tx_on_seen_ff)
        begin
          nxt_tx_state = TX_PREAMBLE;
          nxt_bit_cnt = tx_nine_bit ? PREAMBLE_LONG : PREAMBLE_SHORT;
        end
      end
      TX_PREAMBLE, TX_CHAR:
      begin
        if (bit_tick)
        begin
          nxt_shift = {1'b1, shift_ff[11:1]};
          nxt_bit_cnt = bit_cnt_ff - 4'h1;
          if (bit_cnt_ff == 4'h1)
          begin
            nxt_done = (tx_state_ff == TX_CHAR);
            if (idle_q_ff)
            begin
              // Queued idle: another frame of ones
              nxt_idle_q = 1'b0;
              nxt_tx_state = TX_PREAMBLE;
              nxt_bit_cnt = tx_nine_bit ? PREAMBLE_LONG : PREAMBLE_SHORT;
              nxt_shift = 12'hFFF;
            end
            else if (ctrl_ff.tx_on && tx_char_valid)
            begin
              nxt_tx_state = TX_CHAR;
              nxt_taken = 1'b1;
              nxt_bit_cnt = tx_nine_bit ? CHAR_BITS_LONG : CHAR_BITS_SHORT;
              nxt_shift = tx_nine_bit ? {1'b1, tx_char, 1'b0, 1'b1}
                                      : {2'b11, tx_char[7:0], 1'b0, 1'b1};
            end
            else
            begin
              // Frame finished before idling when tx_on dropped or no character is valid
              nxt_tx_state = TX_IDLE;
              nxt_shift = 12'hFFF;
            end
          end
        end
      end
      default:
      begin
        nxt_tx_state = TX_IDLE;
        nxt_shift = 12'hFFF;
      end
    endcase
  end

  // Sequencer flops; line idles high from reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_state_ff <= TX_IDLE;
      bit_cnt_ff <= 4'h0;
      shift_ff <= 12'hFFF;
      tx_on_seen_ff <= 1'b0;
      idle_q_ff <= 1'b0;
      taken_ff <= 1'b0;
      done_ff <= 1'b0;
    end
    else
    begin
      tx_state_ff <= nxt_tx_state;
      bit_cnt_ff <= nxt_bit_cnt;
      shift_ff <= nxt_shift;
      tx_on_seen_ff <= nxt_tx_on_seen;
      idle_q_ff <= nxt_idle_q;
      taken_ff <= nxt_taken;
      done_ff <= nxt_done;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  sequence rise_on_idle_s;
    tx_state_ff == TX_IDLE && ctrl_ff.tx_on && !tx_on_seen_ff;
  endsequence
  preamble_start_a: assert property (@(posedge pclk) disable iff (!presetn)
    rise_on_idle_s |=> tx_state_ff == TX_PREAMBLE && tx_pin) else $error("no preamble");
  irq_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    (stat_ff & mask_ff & irq_en) != 4'h0 |=> irq) else $error("irq missed");
  irq_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
    (stat_ff & mask_ff & irq_en) == 4'h0 |=> !irq) else $error("spurious irq");
  rx_full_a: assert property (@(posedge pclk) disable iff (!presetn)
    flags_ff.rx_full_flag && ctrl_ff.rx_full_irq_en |=> stat_ff.rx_full_flag)
    else $error("rx full not latched");
  quiet_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    !ctrl_ff.quiet_line_irq_en && !stat_ff.line_quiet_flag |=> !stat_ff.line_quiet_flag)
    else $error("quiet latched while disabled");
  tx_lock_a: assert property (@(posedge pclk) disable iff (!presetn)
    !unit_on_ff |=> $stable(ctrl_ff.tx_on)) else $error("tx_on changed while off");
  finish_char_a: assert property (@(posedge pclk) disable iff (!presetn)
    tx_state_ff == TX_CHAR && !bit_tick |=> tx_state_ff == TX_CHAR)
    else $error("character cut short");
  idle_queue_a: assert property (@(posedge pclk) disable iff (!presetn)
    tx_state_ff == TX_CHAR && ctrl_ff.tx_on && !tx_on_seen_ff |=> idle_q_ff)
    else $error("idle not queued");

endmodule : serial_ctrl_top

/* pkg/serial_ctrl_pkg.sv */
// Package of register map, field layout and timing constants for the serial control block
package serial_ctrl_pkg;

  // ****************************************
  // Register byte addresses
  // ****************************************
  localparam logic [7:0] CTRL_TWO_ADDR = 8'h14;   // Second control register
  localparam logic [7:0] BAUD_ADDR = 8'h18;       // Baud divider select
  localparam logic [7:0] FINE_ADDR = 8'h1C;       // Fine prescaler
  localparam logic [7:0] GLOBAL_ADDR = 8'h20;     // Global serial enable
  localparam logic [7:0] STATUS_ADDR = 8'h24;     // Sticky event status
  localparam logic [7:0] MASK_ADDR = 8'h28;       // Event interrupt mask
  localparam logic [7:0] EVENT_ADDR = 8'h2C;      // Event injection (level flags)

  // ****************************************
  // Field layout and reset values
  // ****************************************
  localparam int TX_EMPTY_BIT = 7;
  localparam int TX_DONE_BIT = 6;
  localparam int RX_FULL_BIT = 5;
  localparam int QUIET_BIT = 4;
  localparam int TX_ON_BIT = 3;
  localparam int RX_ON_BIT = 2;
  localparam int RX_SLEEP_BIT = 1;
  localparam int SEND_BRK_BIT = 0;
  localparam logic [7:0] CTRL_TWO_RESET = 8'h00;
  localparam logic [7:0] BAUD_RESET = 8'h00;
  localparam logic [7:0] FINE_RESET = 8'h00;
  localparam int PRE_SEL_LSB = 4;                 // Baud register bits 5:4
  localparam int RATE_SEL_LSB = 0;                // Baud register bits 2:0
  localparam int FINE_PDS_LSB = 5;                // Fine register bits 7:5
  localparam int FINE_FRAC_W = 5;                 // Fine register bits 4:0
  localparam logic [5:0] FRAC_STEPS = 6'h20;      // Fraction denominator, 32

  // ****************************************
  // Timing constants
  // ****************************************
  localparam logic [6:0] OVERSAMPLE = 7'h40;      // Bus clocks per bit at unity divisors
  localparam logic [3:0] PREAMBLE_SHORT = 4'hA;   // Preamble ones, 8-bit characters
  localparam logic [3:0] PREAMBLE_LONG = 4'hB;    // Preamble ones, 9-bit characters
  localparam logic [3:0] CHAR_BITS_SHORT = 4'hA;  // Start, 8 data, stop
  localparam logic [3:0] CHAR_BITS_LONG = 4'hB;   // Start, 9 data, stop

  // Transmitter line states
  typedef enum logic [1:0]
  {
    TX_IDLE = 2'b00,
    TX_PREAMBLE = 2'b01,
    TX_CHAR = 2'b10
  } tx_state_t;

  // Control fields of the second control register
  typedef struct packed
  {
    logic tx_empty_irq_en;
    logic tx_done_irq_en;
    logic rx_full_irq_en;
    logic quiet_line_irq_en;
    logic tx_on;
    logic rx_on;
    logic rx_sleep;
    logic send_brk;
  } ctrl_two_t;

  // Event flags in the sticky status layout
  typedef struct packed
  {
    logic tx_empty_flag;
    logic tx_done_flag;
    logic rx_full_flag;
    logic line_quiet_flag;
  } events_t;

endpackage : serial_ctrl_pkg

/* verification/far_serial_rx.sv */
// Remote serial receiver model that watches the transmit line
`timescale 1ns/1ps
module far_serial_rx
#(
  parameter int SAMPLE_AT = 32  // Cycles after a bit tick to sample, mid-bit at unity rate
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tx_pin,
  input wire logic bit_tick,
  input wire logic arm,
  input wire logic nine,
  output logic [7:0] gap,
  output logic [8:0] data,
  output logic [7:0] frames,
  output logic stop_ok
);
  // ****************************************
  // Mid-bit sampler and frame capture
  // ****************************************
  logic [7:0] cnt;   // Cycles since the last bit tick
  logic [7:0] ones;  // Ones seen since the last frame or arm
  logic [3:0] bitn;  // Data bits taken in this frame
  logic busy;        // Inside a frame
  logic [8:0] sh;    // Data shifted in from the top, first bit ends at bit 0 in nine-bit mode, bit 1 otherwise
  // Sampling mid-bit keeps the count free of edge-alignment doubt
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      {cnt, ones, bitn, busy, sh, gap, data, frames, stop_ok} <= '0;
    end
    else
    begin
      // Arm hides ticks that came before the new frame, so the count of ones is exact
      if (arm)
        cnt <= 8'h00;
      else if (bit_tick)
        cnt <= 8'h01;
      else if (cnt != 8'h00)
        cnt <= cnt + 8'h01;
      if (arm)
        ones <= 8'h00;
      else if (cnt == SAMPLE_AT[7:0])
      begin
        if (!busy)
        begin
          // Idle ones count up; a zero opens a frame
          if (tx_pin)
            ones <= (ones == 8'hFF) ? ones : ones + 8'h01;
          else
          begin
            busy <= 1'b1;
            gap <= ones;
            ones <= 8'h00;
            bitn <= 4'h0;
          end
        end
        else if (bitn < (nine ? 4'h9 : 4'h8))
        begin
          sh <= {tx_pin, sh[8:1]};
          bitn <= bitn + 4'h1;
        end
        else
        begin
          // Stop position closes the frame
          busy <= 1'b0;
          stop_ok <= tx_pin;
          data <= nine ? sh : {1'b0, sh[8:1]};
          frames <= frames + 8'h01;
        end
      end
    end
  end
endmodule : far_serial_rx

/* verification/serial_ctrl_top_tb_top.sv */
// Self-checking testbench for the serial control top
`timescale 1ns/1ps
module serial_ctrl_top_tb_top;
  import serial_ctrl_pkg::*;
  // ****************************************
  // Stimulus signals and counters
  // ****************************************
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, arm = 1'b0, valid = 1'b0, nine = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, v;
  logic pready, pslverr, err, tx_pin, taken, irq, tick, stop_ok;
  logic [8:0] tx_char = 9'h000, rx_data;
  logic [8:0] c[4];
  logic [7:0] ctrl_out, gap, frames;
  int n_mismatch = 0, checks = 0, seed = 32'h622F, got, k;

  serial_ctrl_top u_serial_ctrl_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .tx_char_valid(valid), .tx_nine_bit(nine),
    .tx_char(tx_char), .tx_pin(tx_pin), .tx_char_taken(taken), .ctrl_two_out(ctrl_out),
    .bit_tick_out(tick), .irq(irq));
  far_serial_rx u_far_serial_rx (.pclk(pclk), .presetn(presetn), .tx_pin(tx_pin),
    .bit_tick(tick), .arm(arm), .nine(nine), .gap(gap), .data(rx_data), .frames(frames),
    .stop_ok(stop_ok));

  // Free-running 125 MHz clock
  initial
  begin
    forever #4 pclk = ~pclk;
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  // One APB transfer; held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    logic rdy;
    int i;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do
    begin
      // Answer is settled before the edge that samples it; keep what stands there
      #1;
      rdy = pready;
      rd = prdata;
      err = pslverr;
      @(posedge pclk);
      i++;
    end
    while (rdy !== 1'b1 && i < 50);
    if (rdy !== 1'b1)
      n_mismatch++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Raise tx_on and restart the far receiver's count of idle ones
  task automatic start_tx();
    apb(1'b1, CTRL_TWO_ADDR, 32'h08);
    arm <= 1'b1;
    @(posedge pclk);
    arm <= 1'b0;
  endtask : start_tx

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask : rdc

  task automatic pause(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask : pause

  // Bounded waits; outputs are looked at once the edge has settled
  task automatic wait_tick(input logic [31:0] lim);
    for (int i = 0; i < lim; i++)
    begin
      pause(1);
      if (tick === 1'b1)
        break;
    end
    if (tick !== 1'b1)
      n_mismatch++;
  endtask : wait_tick

  task automatic wait_taken();
    for (int i = 0; i < 3000; i++)
    begin
      pause(1);
      if (taken === 1'b1)
        break;
    end
    if (taken !== 1'b1)
      n_mismatch++;
  endtask : wait_taken

  task automatic wait_frames(input logic [7:0] n);
    for (int i = 0; i < 3000 && frames !== n; i++)
      pause(1);
    if (frames !== n)
      n_mismatch++;
  endtask : wait_frames

  // Fraction adds one clock per 32 of fr to each fine period: 2 x fr per 64
  function automatic int exp_per(input int p, input int r, input int f, input int fr);
    int pre[4] = '{1, 3, 4, 13};
    return pre[p] * (1 << r) * (64 * ((f == 0) ? 1 : f + 1) + ((f == 0) ? 0 : 2 * fr));
  endfunction : exp_per

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : conclude

  // Watchdog sized well above the expected run length
  initial
  begin
    repeat (90000) @(posedge pclk);
    n_mismatch++;
    conclude();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rdc(CTRL_TWO_ADDR, {24'h0, CTRL_TWO_RESET});
    rdc(BAUD_ADDR, {24'h0, BAUD_RESET});
    chk(ctrl_out, 32'h0);
    rdc(8'h30, 32'h0);
    chk(err, 32'h1);
    // Global enable is still off, so the transmitter enable must not stick
    for (k = 0; k < 4; k++)
    begin
      v = $random(seed);
      apb(1'b1, CTRL_TWO_ADDR, v);
      rdc(CTRL_TWO_ADDR, {24'h0, v[7:0] & 8'hF7});
      chk(ctrl_out, {24'h0, v[7:0] & 8'hF7});
      apb(1'b1, BAUD_ADDR, v & 32'h37);
      rdc(BAUD_ADDR, v & 32'h37);
    end
    apb(1'b1, CTRL_TWO_ADDR, 32'h0);
    $display("register test done");
    // Each event: blocked without its enable, raised, masked, cleared
    for (k = 0; k < 4; k++)
    begin
      apb(1'b1, MASK_ADDR, 32'hF);
      apb(1'b1, EVENT_ADDR, 32'h8 >> k);
      pause(3);
      chk(irq, 32'h0);
      apb(1'b1, CTRL_TWO_ADDR, 32'h80 >> k);
      pause(3);
      chk(irq, 32'h1);
      rdc(STATUS_ADDR, 32'h8 >> k);
      apb(1'b1, MASK_ADDR, 32'h0);
      pause(3);
      chk(irq, 32'h0);
      apb(1'b1, EVENT_ADDR, 32'h0);
      apb(1'b1, STATUS_ADDR, 32'h8 >> k);
      apb(1'b1, MASK_ADDR, 32'hF);
      apb(1'b1, CTRL_TWO_ADDR, 32'h0);
      rdc(STATUS_ADDR, 32'h0);
    end
    $display("interrupt test done");
    // Prescaler codes, rate codes, then three fine settings, one with a fraction
    for (k = 0; k < 14; k++)
    begin
      apb(1'b1, BAUD_ADDR, (k < 4) ? k << 4 : (k < 11) ? k - 3 : 0);
      apb(1'b1, FINE_ADDR, (k == 11) ? 32'h20 : (k == 12) ? 32'hE0 : (k == 13) ? 32'h30 : 32'h0);
      wait_tick(20000);
      wait_tick(20000);
      got = 0;
      do
      begin
        pause(1);
        got++;
      end
      while (tick !== 1'b1 && got < 20000);
      chk(got, exp_per((k < 4) ? k : 0, (k > 3 && k < 11) ? k - 3 : 0,
        (k == 11 || k == 13) ? 1 : (k == 12) ? 7 : 0, (k == 13) ? 16 : 0));
    end
    apb(1'b1, BAUD_ADDR, 32'h0);
    apb(1'b1, FINE_ADDR, 32'h0);
    $display("rate test done");
    for (k = 0; k < 3; k++)
      c[k] = {1'b0, 8'($random(seed))};
    c[3] = 9'($random(seed));
    apb(1'b1, GLOBAL_ADDR, 32'h1);
    tx_char <= c[0];
    valid <= 1'b1;
    start_tx();
    wait_taken();
    tx_char <= c[1];
    // Second character follows at once; toggle during it adds one idle frame
    wait_taken();
    tx_char <= c[2];
    apb(1'b1, CTRL_TWO_ADDR, 32'h00);
    apb(1'b1, CTRL_TWO_ADDR, 32'h08);
    wait_frames(8'h01);
    chk(gap, {28'h0, PREAMBLE_SHORT});
    chk(rx_data, c[0]);
    chk(stop_ok, 32'h1);
    wait_frames(8'h02);
    chk(gap, 32'h0);
    chk(rx_data, c[1]);
    wait_taken();
    apb(1'b1, CTRL_TWO_ADDR, 32'h00);
    wait_frames(8'h03);
    chk(gap, {28'h0, PREAMBLE_SHORT});
    chk(rx_data, c[2]);
    pause(2000);
    chk(frames, 32'h3);
    chk(tx_pin, 32'h1);
    // Nine-bit mode: longer preamble and longer frame
    nine <= 1'b1;
    tx_char <= c[3];
    start_tx();
    wait_taken();
    apb(1'b1, CTRL_TWO_ADDR, 32'h00);
    wait_frames(8'h04);
    chk(gap, {28'h0, PREAMBLE_LONG});
    chk(rx_data, c[3]);
    chk(stop_ok, 32'h1);
    rdc(EVENT_ADDR, 32'h4);
    $display("transmit test done");
    conclude();
  end
endmodule : serial_ctrl_top_tb_top
